// file: rtl/bcirq_regs.vh
/*
 * Register map, field positions, reset values and mode codes for the
 * broadcast unit interrupt flag block.
 * Assumes word-addressed Avalon-MM access with 32-bit data.
 */
`ifndef BCIRQ_REGS_VH
`define BCIRQ_REGS_VH

// word addresses on the avalon slave
`define BCIRQ_ADDR_W          3
`define BCIRQ_OFS_STATUS      3'h0
`define BCIRQ_OFS_ENABLE      3'h1
`define BCIRQ_OFS_FORCE       3'h2
`define BCIRQ_OFS_MODE        3'h3
`define BCIRQ_OFS_PROTECT     3'h4
`define BCIRQ_OFS_CHMODE      3'h5

// bit 31 msb-0 is lsb; channel x sits at bit x+1
`define BCIRQ_NFLAG           13
`define BCIRQ_NCH             12
`define BCIRQ_CONFLICT_BIT    0
`define BCIRQ_FLAGS_RESET     13'h0000
`define BCIRQ_CHMODE_RESET    12'h000
`define BCIRQ_PROTECT_RESET   1'h1
`define BCIRQ_MODE_RESET      2'h0
`define BCIRQ_BAD_ADDR_DATA   32'h00000000

// interrupt signalling modes
`define BCIRQ_MODE_LEVEL      2'h0
`define BCIRQ_MODE_PULSE      2'h1
`define BCIRQ_MODE_PNOTIFY    2'h2
`define BCIRQ_MODE_SINGLE     2'h3

`endif

// file: rtl/bcirq_sync.v
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes inputs are quasi-static levels; wide buses may skew by a cycle.
 */
`timescale 1ns/1ps
module bcirq_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // levels
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // bcirq_sync

// file: rtl/bcirq_edge.v
/*
 * Rising-edge detector on already synchronous levels, one-cycle pulses out.
 * Assumes inputs are in the clk domain.
 */
`timescale 1ns/1ps
module bcirq_edge #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // levels in, pulses out
  input  wire [W-1:0] level,
  output wire [W-1:0] rise
);
  reg [W-1:0] last;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last <= {W{1'b0}};
    end else begin
      last <= level;
    end
  end

  assign rise = level & ~last;
endmodule // bcirq_edge

// file: rtl/bcirq_top.v
/*
 * Interrupt status, enable and force registers of the broadcast unit,
 * an Avalon-MM slave with waitrequest, and the interrupt signalling modes.
 * Assumes error event lines arrive from another domain as levels that rise
 * once per event; they are synchronised and edge detected here.
 */
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "bcirq_regs.vh"

module bcirq_top (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // avalon-mm slave
  input  wire [2:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // error events from the broadcast datapath, asynchronous levels
  input  wire        config_conflict_event,
  input  wire [11:0] inconsistency_event,
  // interrupt out
  output reg         broadcast_unit_irq
);

  // synchronised event levels, then one-cycle pulses
  wire [12:0] ev_sync;
  wire [12:0] ev_pulse;

  bcirq_sync #(.W(`BCIRQ_NFLAG)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({inconsistency_event, config_conflict_event}),
    .q       (ev_sync)
  );

  bcirq_edge #(.W(`BCIRQ_NFLAG)) u_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .level   (ev_sync),
    .rise    (ev_pulse)
  );

  // registers
  reg [12:0] flags;
  reg [12:0] irq_enable;
  reg [1:0]  irq_mode;
  reg        force_write_protect;
  reg [11:0] channel_operation_select;
  reg [12:0] next_flags;
  reg [12:0] hw_set;
  reg [12:0] sw_clr;
  reg [12:0] sw_force;
  reg        served;
  reg [31:0] next_rdata;
  reg [12:0] pend_prev;
  reg        single_armed;
  reg        next_irq;

  // bytes 0 and 1 carry bits 12:0
  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  function [12:0] low13;
    input [31:0] d;
    begin
      low13 = d[12:0];
    end
  endfunction

  wire [31:0] wmask  = lane_mask(avs_byteenable);
  wire [12:0] wbits  = low13(avs_writedata & wmask);
  wire [12:0] wlanes = low13(wmask);
  // write lands at the edge the master sees waitrequest low, not before
  wire        wr_go  = avs_write & ~avs_read & ~avs_waitrequest;
  wire        rd_go  = avs_read & ~avs_write & avs_waitrequest & ~served;

  // one wait state: request sampled, answered the next edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      served          <= 1'b0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest & ~served);
      served          <= (avs_read | avs_write) & avs_waitrequest & ~served;
    end
  end

  always @* begin
    hw_set = {ev_pulse[12:1] & channel_operation_select, ev_pulse[0]};
    sw_clr = {`BCIRQ_NFLAG{1'b0}};
    sw_force = {`BCIRQ_NFLAG{1'b0}};
    if (wr_go && avs_address == `BCIRQ_OFS_STATUS) begin
      sw_clr = wbits;
    end
    if (wr_go && avs_address == `BCIRQ_OFS_FORCE && !force_write_protect) begin
      sw_force = wbits;
    end
    // set wins over a clear in the same cycle
    next_flags = (flags & ~sw_clr) | hw_set | sw_force;
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags                    <= `BCIRQ_FLAGS_RESET;
      irq_enable               <= `BCIRQ_FLAGS_RESET;
      irq_mode                 <= `BCIRQ_MODE_RESET;
      force_write_protect      <= `BCIRQ_PROTECT_RESET;
      channel_operation_select <= `BCIRQ_CHMODE_RESET;
    end else begin
      flags <= next_flags;
      if (wr_go) begin
        case (avs_address)
          `BCIRQ_OFS_ENABLE: begin
            irq_enable <= (irq_enable & ~wlanes) | wbits;
          end
          `BCIRQ_OFS_MODE: begin
            if (avs_byteenable[0]) begin
              irq_mode <= avs_writedata[1:0];
            end
          end
          `BCIRQ_OFS_PROTECT: begin
            if (avs_byteenable[0]) begin
              force_write_protect <= avs_writedata[0];
            end
          end
          `BCIRQ_OFS_CHMODE: begin
            channel_operation_select <= (channel_operation_select & ~wlanes[11:0])
                                        | wbits[11:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; force register always reads zero
  always @* begin
    next_rdata = `BCIRQ_BAD_ADDR_DATA;
    case (avs_address)
      `BCIRQ_OFS_STATUS:  next_rdata = {19'h00000, flags};
      `BCIRQ_OFS_ENABLE:  next_rdata = {19'h00000, irq_enable};
      `BCIRQ_OFS_FORCE:   next_rdata = 32'h00000000;
      `BCIRQ_OFS_MODE:    next_rdata = {30'h0, irq_mode};
      `BCIRQ_OFS_PROTECT: next_rdata = {31'h0, force_write_protect};
      `BCIRQ_OFS_CHMODE:  next_rdata = {20'h00000, channel_operation_select};
      default:            next_rdata = `BCIRQ_BAD_ADDR_DATA;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_go) begin
      avs_readdata <= next_rdata;
    end
  end

  // interrupt signalling
  wire [12:0] pend     = flags & irq_enable;
  wire        any_pend = |pend;
  wire        new_pend = |(pend & ~pend_prev);

  always @* begin
    case (irq_mode)
      `BCIRQ_MODE_LEVEL:   next_irq = any_pend;
      `BCIRQ_MODE_PULSE:   next_irq = new_pend;
      `BCIRQ_MODE_PNOTIFY: next_irq = new_pend;
      `BCIRQ_MODE_SINGLE:  next_irq = new_pend & single_armed;
      default:             next_irq = any_pend;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_prev          <= `BCIRQ_FLAGS_RESET;
      single_armed       <= 1'b1;
      broadcast_unit_irq <= 1'b0;
    end else begin
      pend_prev          <= pend;
      broadcast_unit_irq <= next_irq;
      // single-pulse rearms only once every pending source is gone
      if (!any_pend) begin
        single_armed <= 1'b1;
      end else if (new_pend) begin
        single_armed <= 1'b0;
      end
    end
  end

endmodule // bcirq_top

// file: tb/bcirq_monitor.sv
/* port assertions for the interrupt flag block
   assumes a bind onto bcirq_top, one clock domain */
`timescale 1ns/1ps
module bcirq_monitor (
  // clock and reset
  input logic        clk,
  input logic        sys_rst,
  // bus and interrupt
  input logic [2:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        broadcast_unit_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire rdone = avs_read && !avs_waitrequest;
  property p_ans; (avs_read ^ avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_hold; avs_waitrequest |-> $stable(avs_readdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rsv; rdone |-> avs_readdata[31:13] == 19'h00000; endproperty
  a_rsv: assert property (p_rsv) else $error("upper bits set");
  property p_frc; rdone && avs_address == 3'h2 |-> avs_readdata == 32'h0; endproperty
  a_frc: assert property (p_frc) else $error("force reads one");
  property p_bad; rdone && avs_address > 3'h5 |-> avs_readdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped reads data");
  property p_rst; $fell(sys_rst) |-> !broadcast_unit_irq; endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
endmodule // bcirq_monitor

// file: tb/bcirq_partner.sv
/* interrupt controller model: counts cycles with the interrupt high
   assumes the interrupt is synchronous to clk */
`timescale 1ns/1ps
module bcirq_partner (
  // clock and count clear
  input  logic       clk,
  input  logic       clr,
  // interrupt in, count out
  input  logic       irq,
  output logic [7:0] hits
);
  always @(posedge clk) begin
    if (clr) begin
      hits <= 8'h00;
    end else if (irq === 1'b1) begin
      hits <= hits + 8'h01;
    end
  end
endmodule // bcirq_partner

// file: tb/bcirq_top_tb.sv
/* self-checking bench for the interrupt flag block
   assumes the word map of bcirq_regs.vh */
`timescale 1ns/1ps
module bcirq_top_tb;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, cce, clr;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [11:0] ie;
  logic [7:0]  hits;
  logic [66:0] rows [0:5];
  integer      n_errors = 0, tests_run = 0, cyc = 0, i;
  bcirq_top u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .config_conflict_event(cce),
    .inconsistency_event(ie), .broadcast_unit_irq(irq));
  bcirq_partner u_irqc (.clk(clk), .clr(clr), .irq(irq), .hits(hits));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task complete_run;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one idle edge first so a request is never assigned twice in a step
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) n_errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    {sys_rst, avs_read, avs_write, cce, clr} = 5'b10001;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    ie = 12'h000;
    rows[0] = {3'h1, 32'hFFFFFFFF, 32'h00001FFF};
    rows[1] = {3'h3, 32'h00000000, 32'h00000000};
    rows[2] = {3'h4, 32'h00000000, 32'h00000000};
    rows[3] = {3'h5, 32'h00000FFF, 32'h00000FFF};
    rows[4] = {3'h2, 32'h00001FFF, 32'h00000000};
    rows[5] = {3'h6, 32'hFFFFFFFF, 32'h00000000};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    clr <= 1'b0;
    bus(1'b0, 3'h0, 32'h0); chk("stat", q, 32'h0);
    bus(1'b0, 3'h1, 32'h0); chk("en", q, 32'h0);
    for (i = 0; i < 6; i++) begin
      bus(1'b1, rows[i][66:64], rows[i][63:32]);
      bus(1'b0, rows[i][66:64], 32'h0);
      chk("row", q, rows[i][31:0]);
    end
    bus(1'b0, 3'h0, 32'h0); chk("forced", q, 32'h1FFF);
    bus(1'b0, 3'h0, 32'h0); chk("reread", q, 32'h1FFF);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, 3'h0, 32'h1); bus(1'b0, 3'h0, 32'h0); chk("w1c", q, 32'h1FFE);
    bus(1'b1, 3'h0, 32'h0); bus(1'b0, 3'h0, 32'h0); chk("w0", q, 32'h1FFE);
    bus(1'b1, 3'h1, 32'h0); repeat (3) @(posedge clk);
    chk("masked", {31'h0, irq}, 32'h0);
    bus(1'b1, 3'h0, 32'h1FFE);
    // protection back on, force must be ignored
    bus(1'b1, 3'h4, 32'h1); bus(1'b1, 3'h2, 32'h1);
    bus(1'b0, 3'h0, 32'h0); chk("prot", q, 32'h0);
    bus(1'b1, 3'h4, 32'h0);
    cce <= 1'b1; ie <= 12'h004;
    repeat (8) @(posedge clk);
    bus(1'b0, 3'h0, 32'h0); chk("events", q, 32'h9);
    bus(1'b1, 3'h0, 32'h9); bus(1'b1, 3'h5, 32'h0);
    ie <= 12'h014;
    repeat (8) @(posedge clk);
    bus(1'b0, 3'h0, 32'h0); chk("cmode", q, 32'h0);
    bus(1'b1, 3'h1, 32'h1);
    for (i = 1; i < 4; i++) begin
      bus(1'b1, 3'h3, i[31:0]); clr <= 1'b1; @(posedge clk); clr <= 1'b0;
      bus(1'b1, 3'h2, 32'h1); repeat (6) @(posedge clk);
      chk("pulse", {24'h0, hits}, 32'h1);
      bus(1'b1, 3'h0, 32'h1);
    end
    // mid-run reset with a flag and its enable standing
    bus(1'b1, 3'h3, 32'h0); bus(1'b1, 3'h2, 32'h1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, 3'h0, 32'h0); chk("rst stat", q, 32'h0);
    bus(1'b0, 3'h1, 32'h0); chk("rst en", q, 32'h0);
    chk("rst irq", {31'h0, irq}, 32'h0);
    complete_run;
  end
endmodule // bcirq_top_tb
bind bcirq_top bcirq_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .broadcast_unit_irq(broadcast_unit_irq));
